/* stall_pkg.sv */
// package: constants, register map and carrier types for the stall detect block
//
// Behaviour
// - refresh load reading once per full step, once per four full steps with filter enabled
// - filter enabled: average four step measurements
// - detection gated off below lower velocity threshold
// - load reading zero with detection means stall
// - stop only while stall stop enable set
// - stop forces actual velocity to zero
// - stall flag in driver status while stopped
// - ramp status read clears stop event
// - clearing stall stop enable releases stop
// - threshold offset is signed two's complement
// - load reading unsigned 0..1023, 0 highest load
package stall_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_SWITCH_MODE   = 8'h00;
  localparam logic [7:0] OFS_LOWER_VEL     = 8'h04;
  localparam logic [7:0] OFS_UPPER_VEL     = 8'h08;
  localparam logic [7:0] OFS_LOAD_OFFSET   = 8'h0c;
  localparam logic [7:0] OFS_RAMP_STATUS   = 8'h10;
  localparam logic [7:0] OFS_DRIVER_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS    = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE    = 8'h1c;
  localparam logic [7:0] OFS_IRQ_CLEAR     = 8'h20;

  // switch mode field positions
  localparam int BIT_STALL_STOP_EN = 0;
  localparam int BIT_FILTER_EN     = 1;
  localparam int BIT_SOFT_STOP_EN  = 2;
  // ramp / driver status positions
  localparam int BIT_STOP_EVENT    = 0;
  localparam int BIT_STALL_FLAG    = 24;
  // interrupt bit positions
  localparam int IRQ_STOP          = 0;
  localparam int IRQ_STALL         = 1;
  localparam int IRQ_SAMPLE        = 2;

  // widths and reset values
  localparam int LOAD_W = 10;
  localparam int VEL_W  = 24;
  localparam int OFS_W  = 7;
  localparam int IRQ_W  = 3;
  localparam logic [2:0]       SWITCH_MODE_RST = 3'h0;
  localparam logic [VEL_W-1:0] VEL_THR_RST     = 24'h000000;
  localparam logic [OFS_W-1:0] LOAD_OFFSET_RST = 7'h00;
  localparam int               FILTER_DEPTH    = 4;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // axi4-lite request from master
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axil_req_t;

  // axi4-lite answer from slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  // per full step load measurement from the chopper
  typedef struct packed {
    logic              step;
    logic [LOAD_W-1:0] load;
  } load_sample_t;

endpackage

/* stall_detect_stop_logic.sv */
// stall detection and stop-on-stall logic with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module stall_detect_stop_logic
(
  input  wire logic                   core_clk,       // 250 MHz system clock
  input  wire logic                   rstn,           // async reset, active low
  input  wire stall_pkg::axil_req_t   bus_req,        // register bus request
  output var  stall_pkg::axil_rsp_t   bus_rsp,        // register bus answer
  input  wire stall_pkg::load_sample_t sample,        // raw load per full step
  input  wire logic [23:0]            actual_velocity, // magnitude from ramp
  output var  logic                   force_zero_vel, // ramp holds velocity 0
  output var  logic [6:0]             load_threshold_offset, // to chopper
  output var  logic                   irq             // level interrupt
);
  import stall_pkg::*;

  // all state of the block
  typedef struct packed {
    logic [2:0]        mode;        // switch mode config bits
    logic [VEL_W-1:0]  lower_vel;   // lower velocity threshold
    logic [VEL_W-1:0]  upper_vel;   // upper velocity threshold
    logic [OFS_W-1:0]  load_ofs;    // signed threshold offset
    logic [LOAD_W-1:0] reading;     // current load reading
    logic [LOAD_W+1:0] acc;         // filter accumulator
    logic [1:0]        acc_cnt;     // samples in accumulator
    logic              stop_event;  // latched stall stop event
    logic [IRQ_W-1:0]  irq_stat;    // sticky interrupt status
    logic [IRQ_W-1:0]  irq_en;      // interrupt enables
    logic              aw_got;      // write address held
    logic [7:0]        aw_addr;
    logic              w_got;       // write data held
    logic [31:0]       w_data;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t s_q;  // registered state
  state_t s_d;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the offset names a mapped register
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a <= OFS_IRQ_CLEAR) && (a[1:0] == 2'h0);
  endfunction

  logic       detect_on;  // velocity gate
  logic       stall_seen; // stall on this step
  logic       wr_fire;    // write both halves present
  logic       rd_fire;    // read address taken
  logic [7:0] wa;
  logic [31:0] wd;
  logic [IRQ_W-1:0] irq_set;
  logic [LOAD_W+1:0] acc_sum;
  logic [LOAD_W-1:0] next_reading;  // reading after this edge

  // detection enabled only at or above the lower threshold
  assign detect_on  = actual_velocity >= s_q.lower_vel;
  // zero reading on a fresh step with detection on is a stall
  assign stall_seen = sample.step && detect_on && (next_reading == '0);

  // write address and data, from the holding registers once captured
  assign wa = s_q.aw_got ? s_q.aw_addr : bus_req.awaddr;
  assign wd = s_q.w_got ? s_q.w_data : bus_req.wdata;
  // a write fires once both halves are present and no response waits
  assign wr_fire = (s_q.aw_got || bus_req.awvalid) && (s_q.w_got || bus_req.wvalid)
                   && !s_q.bvalid;
  // a read is taken only while no read data waits
  assign rd_fire = bus_req.arvalid && !s_q.rvalid;
  // running filter sum, wide enough for four full-scale samples
  assign acc_sum = s_q.acc + {2'h0, sample.load};
  // reading after this edge: raw, every fourth step when filtered, else held
  assign next_reading = !sample.step ? s_q.reading :
                        !s_q.mode[BIT_FILTER_EN] ? sample.load :
                        (s_q.acc_cnt == 2'(FILTER_DEPTH - 1)) ? acc_sum[LOAD_W+1:2] :
                        s_q.reading;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_d = s_q;
    irq_set = '0;
    // load reading refresh on each full step, every fourth full step when filtered
    if (sample.step)
    begin
      if (s_q.mode[BIT_FILTER_EN])
      begin
        // average of four: sum then shift by two
        if (s_q.acc_cnt == 2'(FILTER_DEPTH - 1))
        begin
          s_d.reading = next_reading;
          s_d.acc     = '0;
          s_d.acc_cnt = 2'h0;
        end
        else
        begin
          s_d.acc     = acc_sum;
          s_d.acc_cnt = s_q.acc_cnt + 2'h1;
        end
      end
      else
      begin
        // raw per step reading
        s_d.reading = next_reading;
        s_d.acc     = '0;
        s_d.acc_cnt = 2'h0;
      end
      irq_set[IRQ_SAMPLE] = 1'b1;
    end
    // write channel capture
    if (bus_req.awvalid && !s_q.aw_got)
    begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = bus_req.awaddr;
    end
    if (bus_req.wvalid && !s_q.w_got)
    begin
      s_d.w_got  = 1'b1;
      s_d.w_data = bus_req.wdata;
    end
    if (s_q.bvalid && bus_req.bready)
      s_d.bvalid = 1'b0;
    if (s_q.rvalid && bus_req.rready)
      s_d.rvalid = 1'b0;
    // release of stop by disabling stall stop
    if (!s_q.mode[BIT_STALL_STOP_EN])
      s_d.stop_event = 1'b0;
    // register write
    if (wr_fire)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      if (wa == OFS_SWITCH_MODE)
        s_d.mode = wd[2:0];
      else if (wa == OFS_LOWER_VEL)
        s_d.lower_vel = wd[VEL_W-1:0];
      else if (wa == OFS_UPPER_VEL)
        s_d.upper_vel = wd[VEL_W-1:0];
      else if (wa == OFS_LOAD_OFFSET)
        s_d.load_ofs = wd[OFS_W-1:0];
      else if (wa == OFS_IRQ_ENABLE)
        s_d.irq_en = wd[IRQ_W-1:0];
      else if (wa == OFS_IRQ_CLEAR)
        s_d.irq_stat = s_q.irq_stat & ~wd[IRQ_W-1:0];
    end
    // register read
    if (rd_fire)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = is_mapped(bus_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      s_d.rdata  = 32'h0;
      if (bus_req.araddr == OFS_SWITCH_MODE)
        s_d.rdata = {29'h0, s_q.mode};
      else if (bus_req.araddr == OFS_LOWER_VEL)
        s_d.rdata = {8'h0, s_q.lower_vel};
      else if (bus_req.araddr == OFS_UPPER_VEL)
        s_d.rdata = {8'h0, s_q.upper_vel};
      else if (bus_req.araddr == OFS_LOAD_OFFSET)
        s_d.rdata = {{25{s_q.load_ofs[OFS_W-1]}}, s_q.load_ofs};
      else if (bus_req.araddr == OFS_RAMP_STATUS)
      begin
        s_d.rdata[BIT_STOP_EVENT] = s_q.stop_event;
        s_d.stop_event = 1'b0;
      end
      else if (bus_req.araddr == OFS_DRIVER_STATUS)
      begin
        s_d.rdata[LOAD_W-1:0]     = s_q.reading;
        s_d.rdata[BIT_STALL_FLAG] = s_q.stop_event;
      end
      else if (bus_req.araddr == OFS_IRQ_STATUS)
        s_d.rdata = {29'h0, s_q.irq_stat};
      else if (bus_req.araddr == OFS_IRQ_ENABLE)
        s_d.rdata = {29'h0, s_q.irq_en};
    end
    // a stall with stall stop enabled sets the latched stop event, winning over any clear
    if (stall_seen)
    begin
      irq_set[IRQ_STALL] = 1'b1;
      if (s_q.mode[BIT_STALL_STOP_EN])
      begin
        s_d.stop_event = 1'b1;
        irq_set[IRQ_STOP] = 1'b1;
      end
    end
    // sticky status, set beats clear
    s_d.irq_stat = s_d.irq_stat | irq_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q           <= '0;
      s_q.mode      <= SWITCH_MODE_RST;
      s_q.lower_vel <= VEL_THR_RST;
      s_q.upper_vel <= VEL_THR_RST;
      s_q.load_ofs  <= LOAD_OFFSET_RST;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb
  begin
    bus_rsp         = '0;
    bus_rsp.awready = !s_q.aw_got;
    bus_rsp.wready  = !s_q.w_got;
    bus_rsp.bvalid  = s_q.bvalid;
    bus_rsp.bresp   = s_q.bresp;
    bus_rsp.arready = !s_q.rvalid;
    bus_rsp.rvalid  = s_q.rvalid;
    bus_rsp.rdata   = s_q.rdata;
    bus_rsp.rresp   = s_q.rresp;
  end

  // hard stop: ramp velocity forced to zero while event latched
  assign force_zero_vel        = s_q.stop_event;
  assign load_threshold_offset = s_q.load_ofs;
  assign irq                   = |(s_q.irq_stat & s_q.irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // stop path: a stall with stop enabled latches, a disable or a read releases
  chk_stall_stop_set: assert property (@(posedge core_clk) disable iff (!rstn)
    stall_seen && s_q.mode[BIT_STALL_STOP_EN] |=> force_zero_vel)
    else $error("stall with stop enabled did not stop");
  chk_no_stop_disabled: assert property (@(posedge core_clk) disable iff (!rstn)
    !s_q.mode[BIT_STALL_STOP_EN] && !$past(s_q.mode[BIT_STALL_STOP_EN])
      |-> !force_zero_vel)
    else $error("stop held with stall stop disabled");
  chk_disable_release: assert property (@(posedge core_clk) disable iff (!rstn)
    !s_q.mode[BIT_STALL_STOP_EN] |=> !force_zero_vel)
    else $error("disabled stall stop did not release");
  chk_gate_low_vel: assert property (@(posedge core_clk) disable iff (!rstn)
    actual_velocity < s_q.lower_vel |-> !stall_seen)
    else $error("stall seen below lower velocity");
  chk_stop_latched: assert property (@(posedge core_clk) disable iff (!rstn)
    force_zero_vel && !rd_fire && s_q.mode[BIT_STALL_STOP_EN] |=> force_zero_vel)
    else $error("stop event dropped without clear");
  chk_ramp_read_clear: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_fire && bus_req.araddr == OFS_RAMP_STATUS && !stall_seen
      |=> !force_zero_vel ##0 s_q.rvalid)
    else $error("ramp status read did not clear stop");
  // load reading path
  chk_raw_reading: assert property (@(posedge core_clk) disable iff (!rstn)
    sample.step && !s_q.mode[BIT_FILTER_EN] |=> s_q.reading == $past(sample.load))
    else $error("raw reading not refreshed");
  chk_filter_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    sample.step && s_q.mode[BIT_FILTER_EN] && s_q.acc_cnt != 2'h3
      |=> $stable(s_q.reading))
    else $error("filtered reading changed early");
  chk_zero_stall: assert property (@(posedge core_clk) disable iff (!rstn)
    sample.step && detect_on && next_reading == '0 |=> s_q.irq_stat[IRQ_STALL])
    else $error("zero reading missed");
  chk_stall_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_fire && bus_req.araddr == OFS_DRIVER_STATUS
      |=> s_q.rdata[BIT_STALL_FLAG] == $past(s_q.stop_event))
    else $error("stall flag mismatch");
  // status and bus: sticky bits, answers held until taken
  chk_sample_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    sample.step |=> s_q.irq_stat[IRQ_SAMPLE])
    else $error("new sample not flagged");
  chk_stop_sticky: assert property (@(posedge core_clk) disable iff (!rstn)
    s_q.irq_stat[IRQ_STOP] && !(wr_fire && wa == OFS_IRQ_CLEAR)
      |=> s_q.irq_stat[IRQ_STOP])
    else $error("stop status lost without clear");
  chk_bvalid_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_rsp.bvalid && !bus_req.bready |=> bus_rsp.bvalid && $stable(bus_rsp.bresp))
    else $error("write response dropped before taken");
  chk_rvalid_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    bus_rsp.rvalid && !bus_req.rready |=> bus_rsp.rvalid && $stable(bus_rsp.rdata))
    else $error("read data dropped before taken");
  chk_wr_unmapped: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_fire && !is_mapped(wa) |=> bus_rsp.bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  // main scenarios
  cov_release_disable: cover property (@(posedge core_clk) disable iff (!rstn)
    force_zero_vel && !s_q.mode[BIT_STALL_STOP_EN] ##1 !force_zero_vel);
  cov_stop: cover property (@(posedge core_clk) disable iff (!rstn)
    !force_zero_vel ##1 force_zero_vel);
  cov_release_read: cover property (@(posedge core_clk) disable iff (!rstn)
    force_zero_vel ##1 !force_zero_vel && s_q.mode[BIT_STALL_STOP_EN]);
  cov_filter_out: cover property (@(posedge core_clk) disable iff (!rstn)
    sample.step && s_q.mode[BIT_FILTER_EN] && s_q.acc_cnt == 2'h3);

endmodule

`default_nettype wire

/* ramp_model.sv */
// ramp generator stand-in: zero velocity on a stop, restart after a standstill wait
`timescale 1ns/1ps
`default_nettype none

module ramp_model
#(
  parameter int ZERO_WAIT = 8  // standstill cycles before restart
)
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        force_zero_vel,
  input  wire logic [23:0] target_velocity,
  output var  logic [23:0] actual_velocity
);
  int wait_q;  // standstill count after release

  ////////////////////////////////////////////////////////////////////////////
  // velocity register: abrupt stop, hold while latched, delayed restart
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      actual_velocity <= 24'h000000;
      wait_q          <= 0;
    end
    else if (force_zero_vel)
    begin
      actual_velocity <= 24'h000000;
      wait_q          <= ZERO_WAIT;
    end
    else if (wait_q > 0)
      wait_q <= wait_q - 1;
    else
      actual_velocity <= target_velocity;
  end
endmodule

`default_nettype wire

/* stall_detect_stop_logic_tb.sv */
// self-checking bench for the stall detect block
`timescale 1ns/1ps
`default_nettype none

module stall_detect_stop_logic_tb;
  import stall_pkg::*;
  logic         core_clk, rstn, force_zero_vel, irq;
  axil_req_t    bus_req;
  axil_rsp_t    bus_rsp;
  load_sample_t sample;
  logic [23:0]  actual_velocity, target;
  logic [6:0]   load_threshold_offset;
  logic [31:0]  rv;  // last read data
  logic [1:0]   rr;  // last response code
  int num_errors = 0, compares = 0, acc = 0, cnt = 0, exp_load = 0, exp_stop = 0;
  int exp_irq = 0, irq_en = 0, filt = 0, en = 0, x;

  stall_detect_stop_logic dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .sample(sample), .actual_velocity(actual_velocity),
    .force_zero_vel(force_zero_vel), .load_threshold_offset(load_threshold_offset), .irq(irq));
  ramp_model rm (.core_clk(core_clk), .rstn(rstn), .force_zero_vel(force_zero_vel),
    .target_velocity(target), .actual_velocity(actual_velocity));

  // 250 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // verdict and comparisons
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t output got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic hang();
    num_errors++;
    $display("[FAIL] %0t bus wait ran out", $time);
    test_done();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite master tasks, entered just after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    bus_req.awvalid <= 1'b1;
    bus_req.awaddr  <= a;
    bus_req.wvalid  <= 1'b1;
    bus_req.wdata   <= d;
    bus_req.wstrb   <= 4'hf;
    bus_req.bready  <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(negedge core_clk);
      aw = bus_req.awvalid & bus_rsp.awready;
      w  = bus_req.wvalid & bus_rsp.wready;
      b  = bus_rsp.bvalid;
      rr = bus_rsp.bresp;
      @(posedge core_clk);
      if (aw) bus_req.awvalid <= 1'b0;
      if (w) bus_req.wvalid <= 1'b0;
      if (b)
      begin
        bus_req.bready <= 1'b0;
        @(posedge core_clk);
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, r;
    bus_req.arvalid <= 1'b1;
    bus_req.araddr  <= a;
    bus_req.rready  <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(negedge core_clk);
      ar = bus_req.arvalid & bus_rsp.arready;
      r  = bus_rsp.rvalid;
      rv = bus_rsp.rdata;
      rr = bus_rsp.rresp;
      @(posedge core_clk);
      if (ar) bus_req.arvalid <= 1'b0;
      if (r)
      begin
        bus_req.rready <= 1'b0;
        @(posedge core_clk);
        return;
      end
    end
    hang();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // load samples, reference model and output checks
  task automatic chk_out();
    @(posedge core_clk);
    @(negedge core_clk);
    chk_bit(force_zero_vel, exp_stop[0]);
    chk_bit(irq, exp_irq[0] & irq_en[0]);
    @(posedge core_clk);
  endtask

  task automatic step(input int l);
    sample.step <= 1'b1;
    sample.load <= l[9:0];
    @(posedge core_clk);
    sample.step <= 1'b0;
    acc += l;
    cnt++;
    if (!filt || cnt == 4)
    begin
      exp_load = acc / cnt;
      acc      = 0;
      cnt      = 0;
    end
    if (en && !filt && exp_load == 0 && !exp_stop && target >= 24'h000100)
      exp_stop = 1;
    exp_irq |= exp_stop;
    chk_out();
  endtask

  task automatic dstat();
    rd(OFS_DRIVER_STATUS);
    chk_reg(rv, {7'h00, exp_stop[0], 14'h0000, exp_load[9:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    bus_req = '0;
    sample  = '0;
    target  = 24'h0000ff;
    rstn    = 1'b0;
    void'($urandom(68));
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(OFS_SWITCH_MODE);
    chk_reg(rv, 32'h00000000);
    rd(8'h40);
    chk_reg({rr, rv[29:0]}, {RESP_SLVERR, 30'h0});
    wr(8'h40, 32'hffffffff);
    chk_reg({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(OFS_LOWER_VEL, 32'h00000100);
    chk_reg({30'h0, rr}, {30'h0, RESP_OKAY});
    rd(OFS_LOWER_VEL);
    chk_reg(rv, 32'h00000100);
    x = $urandom;
    wr(OFS_UPPER_VEL, x);
    rd(OFS_UPPER_VEL);
    chk_reg(rv, {8'h00, x[23:0]});
    irq_en = 1;
    wr(OFS_IRQ_ENABLE, 32'h00000001);
    en = 1;
    wr(OFS_SWITCH_MODE, 32'h00000001);
    step(0);
    dstat();
    target <= 24'h000100;
    repeat (4) @(posedge core_clk);
    x = 1 + $urandom % 1023;
    step(x);
    dstat();
    step(0);
    dstat();
    repeat (8) @(posedge core_clk);
    chk_out();
    target <= 24'h000200;
    rd(OFS_RAMP_STATUS);
    chk_reg(rv, 32'h00000001);
    exp_stop = 0;
    chk_out();
    dstat();
    repeat (12) @(posedge core_clk);
    step(0);
    en = 0;
    wr(OFS_SWITCH_MODE, 32'h00000000);
    exp_stop = 0;
    chk_out();
    repeat (12) @(posedge core_clk);
    step(0);
    rd(OFS_IRQ_STATUS);
    chk_reg(rv, 32'h00000007);
    irq_en = 0;
    wr(OFS_IRQ_ENABLE, 32'h00000000);
    chk_out();
    irq_en = 1;
    wr(OFS_IRQ_ENABLE, 32'h00000001);
    chk_out();
    exp_irq = 0;
    wr(OFS_IRQ_CLEAR, 32'h00000001);
    chk_out();
    filt = 1;
    wr(OFS_SWITCH_MODE, 32'h00000002);
    for (int i = 0; i < 8; i++)
    begin
      step(1 + $urandom % 1023);
      dstat();
    end
    x = $urandom % 128;
    wr(OFS_LOAD_OFFSET, x);
    rd(OFS_LOAD_OFFSET);
    chk_reg(rv, {{25{x[6]}}, x[6:0]});
    chk_reg({25'h0, load_threshold_offset}, {25'h0, x[6:0]});
    test_done();
  end
endmodule

`default_nettype wire
